/* rtl/hbad_defs.svh */
// shared constants for the host bus address decoder
`ifndef HBAD_DEFS_SVH
`define HBAD_DEFS_SVH
`define HBAD_AW            23
`define HBAD_DW            16
`define HBAD_BOOT_STROBES  4'h8
`define HBAD_CLK_NS        25
`define HBAD_OFFB_DLY_NS   200
`define HBAD_OFFB_CYC      ((`HBAD_OFFB_DLY_NS + `HBAD_CLK_NS - 1) / `HBAD_CLK_NS)
`define HBAD_OFFB_CYC_W    4'(`HBAD_OFFB_CYC)
`define HBAD_SEL_W         24
`endif

/* rtl/hbad_pkg.sv */
// types shared by both ends of the host bus
package hbad_pkg;
  typedef enum logic [3:0] {
    HBAD_IDLE = 4'h1,
    HBAD_WAIT = 4'h2,
    HBAD_ACK  = 4'h4,
    HBAD_DONE = 4'h8
  } hbad_state_t;
endpackage

/* rtl/hbad_bus_if.sv */
// host bus carrier between host and decoder
`timescale 1ns/100ps
interface hbad_bus_if;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        address_strobe_n;
  logic        upper_byte_strobe_n;
  logic        lower_byte_strobe_n;
  logic        read_not_write;
  logic        function_code_bit2;
  logic        transfer_ack_n;
  logic        bus_request_n;
  logic        bus_grant_n;
  modport host (
    output addr, wdata, address_strobe_n, upper_byte_strobe_n,
    output lower_byte_strobe_n, read_not_write, function_code_bit2,
    output bus_grant_n,
    input  rdata, transfer_ack_n, bus_request_n
  );
  modport decoder (
    input  addr, wdata, address_strobe_n, upper_byte_strobe_n,
    input  lower_byte_strobe_n, read_not_write, function_code_bit2,
    input  bus_grant_n,
    output rdata, transfer_ack_n, bus_request_n
  );
endinterface

/* rtl/hbad_decoder.sv */
// address decoder and transfer acknowledge for the host bus
// Function
// R01 - 23-bit word address, 16-bit data, byte lanes
// R02 - single master, no bus request or grant
// R03 - read: strobes together, decoder acknowledges
// R04 - off-board cycles acknowledge 200 ns late
// R05 - host captures data and releases strobes
// R06 - write acknowledge triggered by byte strobes
// R07 - acknowledge may come from other sources
// R08 - sram selects, low window blocked at boot
// R09 - flash banks, bank one serves boot vectors
// R10 - audio dac selects in 512-byte windows
// R11 - internal block selects in 512-byte windows
// R12 - two radio io selects, gap selects nothing
// R13 - serial port and timer chip selects
// R14 - shared auxiliary select 080000-0fffff
// R15 - acquisition ram select, video ram unused
// R16 - peripheral space answered off-board
// R17 - wattmeter and instrument bus windows
// R18 - serial config eeprom access window
// R19 - selects are active-low pulses per cycle
// R20 - acknowledge line is wired-or open drain
// R21 - strobe count saturates at eight
// R22 - unused ranges get no select, no ack
`timescale 1ns/100ps
`include "hbad_defs.svh"
module hbad_decoder (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  hbad_bus_if.decoder      bus,
  input  wire logic [15:0] target_rdata,
  output logic      [15:0] target_wdata,
  output logic             ram_even_select_n,
  output logic             ram_odd_select_n,
  output logic             flash_bank_one_select_n,
  output logic             flash_bank_two_select_n,
  output logic             acq_ram_select_n,
  output logic             ext_modulation_dac_select_n,
  output logic             tone_pair_dac_select_n,
  output logic             khz_dac_select_n,
  output logic             coded_tone_dac_select_n,
  output logic             tone_gen_select_n,
  output logic             tone_rcv_select_n,
  output logic             int_ctl_select_n,
  output logic             cfg_eeprom_select_n,
  output logic             scope_select_n,
  output logic             freq_cnt_select_n,
  output logic             tone_blk_select_n,
  output logic             latch_select_n,
  output logic             keypad_select_n,
  output logic             video_select_n,
  output logic             timer_ctl_select_n,
  output logic             radio_io_select_one_n,
  output logic             radio_io_select_two_n,
  output logic             serial_port_select_n,
  output logic             ext_timer_select_n,
  output logic             aux_peripheral_select_n,
  output logic             option_mem_select_n,
  output logic             wattmeter_range_select_n,
  output logic             wattmeter_zero_select_n,
  output logic             instr_bus_select_n,
  output logic             ack_out,
  output logic             ack_oe
);

  hbad_pkg::hbad_state_t state_ff;
  hbad_pkg::hbad_state_t nxt_state;
  logic [3:0]  boot_cnt_ff;
  logic [3:0]  wait_cnt_ff;
  logic [23:0] sel_ff;
  logic [15:0] rdata_ff;
  logic [15:0] wdata_ff;
  logic        as_prev_ff;

  // word address: a[n] is byte address bit n+1, byte bit 0 comes from the lane strobes
  wire [22:0] a = bus.addr;
  // count on strobe release so a write's late data phase still sees boot
  wire        as_rise = ~as_prev_ff & bus.address_strobe_n;
  wire        boot = (boot_cnt_ff != `HBAD_BOOT_STROBES);
  wire        ds_act = ~bus.upper_byte_strobe_n | ~bus.lower_byte_strobe_n;
  wire        periph = bus.function_code_bit2 & a[22];             // R16

  // 512-byte window index for the 004000-005fff area
  function automatic logic blk(input logic [22:0] ad, input logic [3:0] n);
    blk = (ad[22:12] == 11'h002) & (ad[11:8] == n);
  endfunction

  // region decode, continuous so the select bank is one flop later
  wire low_win   = (a[22:13] == 10'h000);
  wire d_ram_lo  = low_win & ~boot;                                // R08
  wire d_ram_hi  = ~a[22] & (a[21:19] == 3'h1);                    // R08
  wire d_fl_one  = (~a[22] & (a[21:19] == 3'h4 | a[21:19] == 3'h5))
                 | (low_win & boot);                               // R09
  wire d_fl_two  = ~a[22] & (a[21:19] == 3'h6 | a[21:19] == 3'h7); // R09
  wire d_acq     = ~a[22] & (a[21:19] == 3'h3);                    // R15
  wire d_ser     = (a[22:16] == 7'h02);                            // R13
  wire d_tmr     = (a[22:16] == 7'h03);                            // R13
  wire d_aux     = (a[22:18] == 5'h01);                            // R14
  wire d_rio1    = (a[22:11] == 12'h006);                          // R12
  wire d_rio2    = (a[22:11] == 12'h007);                          // R12
  wire d_optm    = periph & (a[21:17] == 5'h00 | a[21:15] == 7'h04);
  wire d_wrng    = periph & (a == 23'h43_0000);                    // R17
  wire d_wzero   = periph & (a == 23'h43_1800);                    // R17
  wire d_ibus    = periph & (a[21:11] == 11'h064);                 // R17
  wire offboard  = periph | d_aux | d_rio1 | d_rio2;               // R04

  // every on-board or off-board hit; video ram and gaps are not here
  wire [23:0] hit = {d_ram_lo | d_ram_hi, d_fl_one, d_fl_two, d_acq,
                     blk(a, 4'h0), blk(a, 4'h1), blk(a, 4'h2),
                     blk(a, 4'h3), blk(a, 4'h4), blk(a, 4'h5),
                     blk(a, 4'h6), blk(a, 4'h7), blk(a, 4'h8),
                     blk(a, 4'ha), blk(a, 4'hb), blk(a, 4'hc),
                     blk(a, 4'hd), blk(a, 4'he), blk(a, 4'hf),
                     d_rio1 | d_rio2, d_ser | d_tmr, d_aux, d_optm,
                     d_wrng | d_wzero | d_ibus};                   // R10 R11
  wire mapped = |hit;                                              // R22

  // a cycle is decoded once strobes say the data phase is live
  wire go = ~bus.address_strobe_n & ds_act & mapped;               // R03 R06

  // cycle state: wait for byte strobes, delay off-board, hold ack
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hbad_pkg::HBAD_IDLE: if (go) nxt_state = offboard ?
                             hbad_pkg::HBAD_WAIT : hbad_pkg::HBAD_ACK;
      hbad_pkg::HBAD_WAIT: if (wait_cnt_ff == 4'h1)
                             nxt_state = hbad_pkg::HBAD_ACK;
      hbad_pkg::HBAD_ACK:  if (bus.address_strobe_n)
                             nxt_state = hbad_pkg::HBAD_IDLE;      // R05
      default:             nxt_state = hbad_pkg::HBAD_IDLE;
    endcase
    if (bus.address_strobe_n) nxt_state = hbad_pkg::HBAD_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) state_ff <= hbad_pkg::HBAD_IDLE;
    else        state_ff <= nxt_state;
  end

  // off-board hold-off counter, 200 ns or eight sys_clk clocks
  always_ff @(posedge sys_clk) begin
    if (!rst_n)                                wait_cnt_ff <= 4'h0;
    else if (state_ff == hbad_pkg::HBAD_IDLE)  wait_cnt_ff <= `HBAD_OFFB_CYC_W;
    else if (wait_cnt_ff != 4'h0)              wait_cnt_ff <= wait_cnt_ff - 4'h1;
  end // R04

  // boot strobe counter saturates; only reset restarts redirection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      boot_cnt_ff <= 4'h0;
      as_prev_ff  <= 1'b1;
    end else begin
      as_prev_ff <= bus.address_strobe_n;
      if (as_rise & boot) boot_cnt_ff <= boot_cnt_ff + 4'h1;      // R21
    end
  end

  // selects are held from decode until the strobe rises, so the
  // release is the rising edge that clocks the target latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n || bus.address_strobe_n) sel_ff <= '0;
    else if (state_ff == hbad_pkg::HBAD_IDLE && go) sel_ff <= hit; // R19
  end

  // data paths registered; read data caught while the strobe is low,
  // so it is already valid at the edge where the host sees the ack
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
    end else begin
      if (!bus.address_strobe_n) rdata_ff <= target_rdata;
      if (!bus.read_not_write && go) wdata_ff <= bus.wdata;
    end
  end // R01

  // byte lanes steer the sram even and odd halves
  wire ram_hit = sel_ff[23];
  assign ram_even_select_n  = ~(ram_hit & ~bus.upper_byte_strobe_n); // R08
  assign ram_odd_select_n   = ~(ram_hit & ~bus.lower_byte_strobe_n); // R08
  assign flash_bank_one_select_n     = ~sel_ff[22];
  assign flash_bank_two_select_n     = ~sel_ff[21];
  assign acq_ram_select_n            = ~sel_ff[20];
  assign ext_modulation_dac_select_n = ~sel_ff[19];
  assign tone_pair_dac_select_n      = ~sel_ff[18];
  assign khz_dac_select_n            = ~sel_ff[17];
  assign coded_tone_dac_select_n     = ~sel_ff[16];
  assign tone_gen_select_n           = ~sel_ff[15];
  assign tone_rcv_select_n           = ~sel_ff[14];
  assign int_ctl_select_n            = ~sel_ff[13];
  assign cfg_eeprom_select_n         = ~sel_ff[12]; // R18
  assign scope_select_n              = ~sel_ff[11];
  assign freq_cnt_select_n           = ~sel_ff[10];
  assign tone_blk_select_n           = ~sel_ff[9];
  assign latch_select_n              = ~sel_ff[8];
  assign keypad_select_n             = ~sel_ff[7];
  assign video_select_n              = ~sel_ff[6];
  assign timer_ctl_select_n          = ~sel_ff[5];
  assign radio_io_select_one_n = ~(sel_ff[4] & ~a[11]);           // R12
  assign radio_io_select_two_n = ~(sel_ff[4] & a[11]);            // R12
  assign serial_port_select_n  = ~(sel_ff[3] & ~a[16]);           // R13
  assign ext_timer_select_n    = ~(sel_ff[3] & a[16]);            // R13
  assign aux_peripheral_select_n  = ~sel_ff[2];                   // R14
  assign option_mem_select_n      = ~sel_ff[1];                   // R16
  assign wattmeter_range_select_n = ~(sel_ff[0] & ~a[13] & ~a[12]);
  assign wattmeter_zero_select_n  = ~(sel_ff[0] & ~a[13] & a[12]);
  assign instr_bus_select_n       = ~(sel_ff[0] & a[13]);         // R17

  // open-drain ack: pull low only, other sources may share the line
  assign ack_out = 1'b0;                                          // R20
  assign ack_oe  = (state_ff == hbad_pkg::HBAD_ACK);              // R03 R07
  assign bus.transfer_ack_n = ~ack_oe;
  assign bus.rdata = rdata_ff;
  assign target_wdata = wdata_ff;
  assign bus.bus_request_n = 1'b1;                                // R02
endmodule

/* rtl/hbad_host.sv */
// host end: runs strobe and acknowledge cycles for a user request
`timescale 1ns/100ps
`include "hbad_defs.svh"
module hbad_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  hbad_bus_if.host         bus,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_periph,
  input  wire logic [22:0] req_addr,
  input  wire logic [1:0]  req_lanes,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output logic      [15:0] rsp_rdata
);
  hbad_pkg::hbad_state_t state_ff;
  hbad_pkg::hbad_state_t nxt_state;
  logic [22:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [1:0]  lanes_ff;
  logic        write_ff;
  logic        fc2_ff;
  logic        done_ff;

  wire acked = ~bus.transfer_ack_n;

  // idle, address phase, data phase waiting ack, release
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hbad_pkg::HBAD_IDLE: if (req_valid) nxt_state = hbad_pkg::HBAD_WAIT;
      hbad_pkg::HBAD_WAIT: nxt_state = hbad_pkg::HBAD_ACK;          // R06
      hbad_pkg::HBAD_ACK:  if (acked) nxt_state = hbad_pkg::HBAD_DONE;
      hbad_pkg::HBAD_DONE: nxt_state = hbad_pkg::HBAD_IDLE;
      default:             nxt_state = hbad_pkg::HBAD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) state_ff <= hbad_pkg::HBAD_IDLE;
    else        state_ff <= nxt_state;
  end

  // capture request at acceptance; read data at acknowledge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_ff  <= 23'h00_0000;
      wdata_ff <= 16'h0000;
      lanes_ff <= 2'h0;
      write_ff <= 1'b0;
      fc2_ff   <= 1'b0;
      rdata_ff <= 16'h0000;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == hbad_pkg::HBAD_IDLE && req_valid) begin
        addr_ff  <= req_addr;
        wdata_ff <= req_wdata;
        lanes_ff <= req_lanes;
        write_ff <= req_write;
        fc2_ff   <= req_periph;
      end
      if (state_ff == hbad_pkg::HBAD_ACK && acked) begin
        rdata_ff <= bus.rdata;                                    // R05
        done_ff  <= 1'b1;
      end
    end
  end

  // reads raise byte strobes with address strobe; writes one clock later
  wire as_on = (state_ff == hbad_pkg::HBAD_WAIT)
             | (state_ff == hbad_pkg::HBAD_ACK);
  wire ds_on = (state_ff == hbad_pkg::HBAD_ACK) | (as_on & ~write_ff); // R03
  assign bus.address_strobe_n    = ~as_on;
  assign bus.upper_byte_strobe_n = ~(ds_on & lanes_ff[1]);        // R01
  assign bus.lower_byte_strobe_n = ~(ds_on & lanes_ff[0]);
  assign bus.read_not_write      = ~(write_ff & as_on);
  assign bus.function_code_bit2  = fc2_ff;
  assign bus.addr                = addr_ff;
  assign bus.wdata               = wdata_ff;
  assign bus.bus_grant_n         = 1'b1;                          // R02
  assign req_ready = (state_ff == hbad_pkg::HBAD_IDLE);
  assign rsp_valid = done_ff;
  assign rsp_rdata = rdata_ff;
endmodule

/* bench/hbad_props.sv */
// concurrent checks on the host bus between host and decoder ends
`timescale 1ns/100ps
module hbad_props (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [22:0] addr,
  input wire logic        address_strobe_n,
  input wire logic        upper_byte_strobe_n,
  input wire logic        lower_byte_strobe_n,
  input wire logic        read_not_write,
  input wire logic        function_code_bit2,
  input wire logic        transfer_ack_n,
  input wire logic        bus_request_n,
  input wire logic        bus_grant_n
);
  // byte address and region classes, worked out from the map
  wire [23:0] ba     = {addr, 1'b0};
  wire        ds_low = !(upper_byte_strobe_n && lower_byte_strobe_n);
  wire        offb   = (function_code_bit2 && ba[23]) ||
                       (ba[23:13] == 11'h003) || (ba[23:19] == 5'h01);
  wire        unm    = (ba[23:9] == 15'h0029) || (ba[23:20] == 4'h2) ||
                       ((ba[23:18] == 6'h00) && (ba[17:15] != 3'h0));
  wire        onb    = !offb && !unm && !ba[23];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // off-board targets need the data bus held off for 200 ns
  sequence s_offb_hold;
    transfer_ack_n [*7];
  endsequence
  // write: byte strobes follow the address strobe by one clock
  sequence s_ds_next;
    (upper_byte_strobe_n && lower_byte_strobe_n) ##1 ds_low;
  endsequence

  property p_no_arb;
    bus_request_n && bus_grant_n;
  endproperty
  a_no_arb: assert property (p_no_arb)
    else $error("bus request or grant asserted");
  property p_rd_together;
    $fell(address_strobe_n) && read_not_write |-> ds_low;
  endproperty
  a_rd_together: assert property (p_rd_together)
    else $error("read byte strobes late");
  property p_wr_late;
    $fell(address_strobe_n) && !read_not_write |-> s_ds_next;
  endproperty
  a_wr_late: assert property (p_wr_late)
    else $error("write byte strobes not one clock late");
  property p_ack_onb;
    $rose(ds_low) && onb |-> ##[1:3] !transfer_ack_n;
  endproperty
  a_ack_onb: assert property (p_ack_onb)
    else $error("on-board cycle not acknowledged");
  property p_ack_offb;
    $rose(ds_low) && offb |-> s_offb_hold ##[1:4] !transfer_ack_n;
  endproperty
  a_ack_offb: assert property (p_ack_offb)
    else $error("off-board acknowledge timing wrong");
  property p_no_ack_unm;
    !address_strobe_n && unm |-> transfer_ack_n;
  endproperty
  a_no_ack_unm: assert property (p_no_ack_unm)
    else $error("acknowledge on unused address");
  property p_ack_stands;
    !transfer_ack_n && !address_strobe_n |=>
      !transfer_ack_n || address_strobe_n;
  endproperty
  a_ack_stands: assert property (p_ack_stands)
    else $error("acknowledge dropped inside cycle");
  property p_ack_release;
    $rose(address_strobe_n) |=> transfer_ack_n;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge held after strobe release");
endmodule

/* bench/host_bus_address_decoder_bench.sv */
// self-checking bench: host end drives decoder end across the bus
`timescale 1ns/100ps
module host_bus_address_decoder_bench;
  typedef struct {logic [28:0] mask; logic wr; logic [15:0] data;} hbad_exp_t;
  logic        sys_clk, rst_n, req_valid, req_write, req_periph;
  logic [22:0] req_addr;
  logic [1:0]  req_lanes;
  logic [15:0] req_wdata, target_rdata;
  logic [28:0] seen;
  logic [31:0] rnd, seed;
  wire         req_ready, rsp_valid;
  wire  [15:0] rsp_rdata, target_wdata;
  wire  [28:0] sel_n;
  wire         ack_out, ack_oe;
  int          err_count, n_tests, bad;
  hbad_exp_t   exp_q[$];
  hbad_exp_t   e;
  // map probes: byte address and index of the one select expected low
  logic [23:0] tab_a [34] = '{24'h00_4000, 24'h00_41fe, 24'h00_4200,
    24'h00_4400, 24'h00_47fe, 24'h00_4800, 24'h00_4a00, 24'h00_4c00,
    24'h00_4e00, 24'h00_5000, 24'h00_5400, 24'h00_5600, 24'h00_5800,
    24'h00_5a00, 24'h00_5c00, 24'h00_5ffe, 24'h00_6000, 24'h00_6ffe,
    24'h00_7000, 24'h04_0000, 24'h05_fffe, 24'h06_0000, 24'h08_0000,
    24'h0f_fffe, 24'h30_0000, 24'h40_0000, 24'h5f_fffe, 24'h60_0000,
    24'h7f_fffe, 24'h80_0000, 24'h84_fffe, 24'h86_0000, 24'h86_3000,
    24'h86_4000};
  int tab_k [34] = '{23, 23, 22, 21, 20, 19, 18, 17, 16, 15, 14, 13, 12,
    11, 10, 9, 8, 8, 7, 6, 6, 5, 4, 4, 24, 26, 26, 25, 25, 3, 3, 2, 1, 0};
  logic [23:0] unm_a [3] = '{24'h00_5200, 24'h00_8000, 24'h20_0000};

  hbad_bus_if u_hbad_bus_if ();
  hbad_host u_hbad_host (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(u_hbad_bus_if), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_periph(req_periph), .req_addr(req_addr),
    .req_lanes(req_lanes), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  hbad_decoder u_hbad_decoder (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(u_hbad_bus_if), .target_rdata(target_rdata),
    .target_wdata(target_wdata), .ram_even_select_n(sel_n[28]),
    .ram_odd_select_n(sel_n[27]), .flash_bank_one_select_n(sel_n[26]),
    .flash_bank_two_select_n(sel_n[25]), .acq_ram_select_n(sel_n[24]),
    .ext_modulation_dac_select_n(sel_n[23]),
    .tone_pair_dac_select_n(sel_n[22]), .khz_dac_select_n(sel_n[21]),
    .coded_tone_dac_select_n(sel_n[20]), .tone_gen_select_n(sel_n[19]),
    .tone_rcv_select_n(sel_n[18]), .int_ctl_select_n(sel_n[17]),
    .cfg_eeprom_select_n(sel_n[16]), .scope_select_n(sel_n[15]),
    .freq_cnt_select_n(sel_n[14]), .tone_blk_select_n(sel_n[13]),
    .latch_select_n(sel_n[12]), .keypad_select_n(sel_n[11]),
    .video_select_n(sel_n[10]), .timer_ctl_select_n(sel_n[9]),
    .radio_io_select_one_n(sel_n[8]), .radio_io_select_two_n(sel_n[7]),
    .serial_port_select_n(sel_n[6]), .ext_timer_select_n(sel_n[5]),
    .aux_peripheral_select_n(sel_n[4]), .option_mem_select_n(sel_n[3]),
    .wattmeter_range_select_n(sel_n[2]),
    .wattmeter_zero_select_n(sel_n[1]), .instr_bus_select_n(sel_n[0]),
    .ack_out(ack_out), .ack_oe(ack_oe));
  hbad_props u_hbad_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr(u_hbad_bus_if.addr),
    .address_strobe_n(u_hbad_bus_if.address_strobe_n),
    .upper_byte_strobe_n(u_hbad_bus_if.upper_byte_strobe_n),
    .lower_byte_strobe_n(u_hbad_bus_if.lower_byte_strobe_n),
    .read_not_write(u_hbad_bus_if.read_not_write),
    .function_code_bit2(u_hbad_bus_if.function_code_bit2),
    .transfer_ack_n(u_hbad_bus_if.transfer_ack_n),
    .bus_request_n(u_hbad_bus_if.bus_request_n),
    .bus_grant_n(u_hbad_bus_if.bus_grant_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, got, want);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one transfer with random direction and data; hang means no answer due
  task automatic xfer(input logic [23:0] ba, input logic [1:0] ln,
                      input logic [28:0] mask, input logic hang);
    hbad_exp_t x;
    @(negedge sys_clk);
    while (req_ready !== 1'b1) @(negedge sys_clk);
    rnd = $random(seed);
    req_write = rnd[0];
    req_wdata = rnd[31:16];
    target_rdata = rnd[15:0];
    req_addr = ba[23:1];
    req_periph = ba[23];
    req_lanes = ln;
    req_valid = 1'b1;
    x.mask = mask;
    x.wr = rnd[0];
    x.data = rnd[0] ? rnd[31:16] : rnd[15:0];
    if (!hang) exp_q.push_back(x);
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (!hang && exp_q.size() != 0) @(negedge sys_clk);
  endtask

  // selects are captured while acknowledged, judged when the host answers
  always @(negedge sys_clk) begin
    // only while the strobe is low: lane-gated selects drop at release
    if (u_hbad_bus_if.transfer_ack_n === 1'b0 &&
        u_hbad_bus_if.address_strobe_n === 1'b0) seen = ~sel_n;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h0000_0001, 32'h0000_0000);
      end else begin
        e = exp_q.pop_front();
        chk(32'(seen), 32'(e.mask));
        chk(32'(e.wr ? target_wdata : rsp_rdata), 32'(e.data));
        chk(32'(ack_oe), 32'h0000_0001);
        seen = '0;
      end
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    close_out();
  end

  initial begin
    {rst_n, req_valid, req_write, req_periph} = '0;
    {req_addr, req_lanes, req_wdata, target_rdata, seen} = '0;
    seed = 32'h0000_178b;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    // first eight strobes, read or write, hit boot vectors in flash bank one
    for (int i = 0; i < 8; i++) xfer(24'h00_0000, 2'b11, 29'h1 << 26, 0);
    xfer(24'h00_3ffe, 2'b11, 29'h1800_0000, 0);
    xfer(24'h10_0000, 2'b10, 29'h1000_0000, 0);
    xfer(24'h1f_fffe, 2'b01, 29'h0800_0000, 0);
    $display("boot and ram test done");
    for (int i = 0; i < 34; i++) xfer(tab_a[i], 2'b01, 29'h1 << tab_k[i], 0);
    $display("map test done");
    // unused ranges: no select, no answer; only a reset frees the host
    for (int i = 0; i < 3; i++) begin
      xfer(unm_a[i], 2'b11, '0, 1);
      bad = 0;
      repeat (40) begin
        @(negedge sys_clk);
        if (sel_n !== '1 || rsp_valid !== 1'b0) bad++;
        if (u_hbad_bus_if.transfer_ack_n !== 1'b1) bad++;
        if (ack_oe !== 1'b0 || ack_out !== 1'b0) bad++;
      end
      chk(32'(bad), 32'h0000_0000);
      rst_n = 1'b0;
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
    end
    xfer(24'h00_0000, 2'b11, 29'h1 << 26, 0);
    $display("unused range test done");
    close_out();
  end
endmodule
